// >>> rtl/fra_map.svh
/*
  Constants of the fuse and ROM identity block: read addresses,
  fuse ranges, host register offsets and fields, timing.
  Assumes inclusion by bare name from the fuse array, device, host and bench files.
*/
`ifndef FRA_MAP_SVH
`define FRA_MAP_SVH
// ----------------------------------------
// read addresses seen over the link
// ----------------------------------------
`define FRA_ROM_ID_ADDR 4'h0
`define FRA_ROM_REV_ADDR 4'h1
`define FRA_FUSE_W0_ADDR 4'h2
`define FRA_FUSE_W1_ADDR 4'h3
`define FRA_FUSE_W2_ADDR 4'h4
`define FRA_FUSE_W3_ADDR 4'h5
// ----------------------------------------
// fuse ranges
// ----------------------------------------
`define FRA_FUSE_COUNT 128
`define FRA_SECRET_HI 63
`define FRA_STATUS_LO 64
`define FRA_STATUS_HI 86
`define FRA_LOCK_BIT 87
`define FRA_MAKER_LO 88
`define FRA_SERIAL_LO 96
// ----------------------------------------
// host register offsets and fields
// ----------------------------------------
`define FRA_REG_CTRL 12'h000
`define FRA_REG_ARG_LO 12'h004
`define FRA_REG_ARG_HI 12'h008
`define FRA_REG_STATUS 12'h00c
`define FRA_REG_RDATA 12'h010
`define FRA_CTRL_OP_LSB 0
`define FRA_CTRL_GO_BIT 3
`define FRA_CTRL_WAKE_BIT 4
`define FRA_CTRL_SEL_LSB 5
`define FRA_CTRL_ADDR_LSB 8
// ----------------------------------------
// timing: watchdog interval
// ----------------------------------------
`define FRA_CLK_MHZ 200
`define FRA_WDOG_US 1000
`define FRA_WDOG_CYC (`FRA_WDOG_US * `FRA_CLK_MHZ)
`endif

// >>> rtl/fra_pkg.sv
/*
  Types shared by both ends of the fuse and ROM identity link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fra_pkg;
  // command codes carried on the link
  typedef enum logic [2:0] {
    FRA_OP_READ = 3'h0,
    FRA_OP_BURN = 3'h1,
    FRA_OP_V0 = 3'h2,
    FRA_OP_V1 = 3'h3,
    FRA_OP_V2 = 3'h4
  } fra_op_t;
  // device sequencer states
  typedef enum logic [2:0] {
    FRA_ST_SLEEP = 3'b001,
    FRA_ST_IDLE = 3'b010,
    FRA_ST_RESP = 3'b100
  } fra_dev_st_t;
  // host sequencer states
  typedef enum logic [2:0] {
    FRA_HS_IDLE = 3'b001,
    FRA_HS_ISSUE = 3'b010,
    FRA_HS_WAIT = 3'b100
  } fra_host_st_t;
endpackage : fra_pkg
`default_nettype wire

// >>> rtl/fra_link_if.sv
/*
  Command-level link between host controller and identity device.
  Assumes both ends run on the same clock; wire framing is abstracted.
*/
`default_nettype none
interface fra_link_if;
  import fra_pkg::*;
  logic wake;
  logic cmd_valid;
  logic cmd_ready;
  fra_op_t cmd_op;
  logic [3:0] cmd_addr;
  logic [1:0] cmd_sel;
  logic [63:0] cmd_arg;
  logic rsp_valid;
  logic rsp_ok;
  logic [31:0] rsp_data;
  logic awake;
  modport dev (input wake, cmd_valid, cmd_op, cmd_addr, cmd_sel, cmd_arg,
    output cmd_ready, rsp_valid, rsp_ok, rsp_data, awake);
  modport host (output wake, cmd_valid, cmd_op, cmd_addr, cmd_sel, cmd_arg,
    input cmd_ready, rsp_valid, rsp_ok, rsp_data, awake);
endinterface : fra_link_if
`default_nettype wire

// >>> rtl/fra_fuse_array.sv
/*
  One-time fuse array: burn-only storage with factory identity bits.
  Assumes the owner gates burn requests; identity bits are never burnable.
*/
`default_nettype none
`include "fra_map.svh"
module fra_fuse_array
  import fra_pkg::*;
#(
  parameter int NFUSE = `FRA_FUSE_COUNT,
  parameter logic [7:0] MAKER_FUSE = 8'h5a,
  parameter logic [31:0] SERIAL_FUSE = 32'h0000_0001
) (
  input wire logic core_clk_in,
  input wire logic ce_in,
  input wire logic burn_in,
  input wire logic [NFUSE-1:0] burn_mask_in,
  output logic [NFUSE-1:0] fuse_out
);
  // ----------------------------------------
  // burned state
  // ----------------------------------------
  // nonvolatile: no reset touches it, the initialiser stands for shipment
  logic [NFUSE-1:0] blown_q = '0;
  logic [NFUSE-1:0] burnable;

  // only fuses below the identity ranges can ever be burned
  assign burnable = {{(NFUSE-`FRA_MAKER_LO){1'b0}}, {`FRA_MAKER_LO{1'b1}}};

  always_ff @(posedge core_clk_in) begin
    if (ce_in && burn_in) begin
      blown_q <= blown_q | (burn_mask_in & burnable);
    end
  end

  // identity bits fixed at the factory
  assign fuse_out = {SERIAL_FUSE, MAKER_FUSE,
    ~blown_q[`FRA_MAKER_LO-1:0]};
endmodule // fra_fuse_array
`default_nettype wire

// >>> rtl/fra_device.sv
/*
  Identity device end: fuse array, readable ROM words, secure burn,
  three-step response check and failsafe watchdog.
  Assumes the host end keeps one command in flight and wakes the device first.
*/
// Decided for this implementation: register access over APB.
`default_nettype none
`include "fra_map.svh"
// Summary of operation
// - 128 fuses, burning is irreversible
// - unburned reads one, burned reads zero
// - secret fuses 0-63 burnable, never readable
// - status fuses 64-86 burnable and readable
// - secrets ignored until lock fuse burns
// - lock fuse burned blocks further burns
// - fuses 88-95 factory maker code
// - fuses 96-127 factory serial part
// - only first 64 ROM bits readable
// - word 0 bytes 0-1 maker code swapped
// - word 0 bytes 2-3 wafer serial
// - word 1 revision bytes, unreliable value
// - wafer serial never digested
// - serial number digested only when selected
// - 24-bit maker id in every computation
// - any subset of secret fuses burnable
// - status fuses not appended, host supplies
// - return only pass or fail
// - host supplies the random challenge
// - watchdog forces sleep after fixed interval
// - verify runs as steps zero, one, two
// - full maker id in every digest
module fra_device
  import fra_pkg::*;
#(
  parameter int unsigned WDOG_CYC = `FRA_WDOG_CYC,
  parameter logic [15:0] ROM_MAKER = 16'h1a2b,   // arbitrary value
  parameter logic [15:0] WAFER_SN = 16'h0007,
  parameter logic [31:0] REVISION = 32'h0000_0001, // arbitrary value
  parameter logic [7:0] MAKER_FUSE = 8'h5a,       // arbitrary value
  parameter logic [31:0] SERIAL_FUSE = 32'h0000_0001,
  parameter logic [63:0] MASK_KEY = 64'h0f1e_2d3c_4b5a_6978
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  fra_link_if.dev link,
  output logic asleep_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  fra_dev_st_t st_q;
  logic [31:0] wdog_q;
  logic wdog_hit;
  logic [1:0] step_q;       // next verify step expected
  logic [63:0] chal_q;
  logic [63:0] extra_q;
  logic rsp_ok_q;
  logic [31:0] rsp_data_q;
  logic [127:0] fuse;
  logic burn_go;
  logic [127:0] burn_mask;
  logic lock_burned;
  logic take;
  logic [63:0] secret_part;
  logic [63:0] serial_part;
  logic [63:0] msg;
  logic [63:0] digest;
  logic rd_ok;
  logic [31:0] rd_data;

  fra_fuse_array #(
    .NFUSE(`FRA_FUSE_COUNT),
    .MAKER_FUSE(MAKER_FUSE),
    .SERIAL_FUSE(SERIAL_FUSE)
  ) u_fuse (
    .core_clk_in(core_clk_in),
    .ce_in(ce_in),
    .burn_in(burn_go),
    .burn_mask_in(burn_mask),
    .fuse_out(fuse)
  );

  assign lock_burned = ~fuse[`FRA_LOCK_BIT];
  assign take = link.cmd_valid && link.cmd_ready;
  assign link.cmd_ready = ce_in && (st_q == FRA_ST_IDLE) && !wdog_hit;
  assign link.rsp_valid = (st_q == FRA_ST_RESP);
  assign link.rsp_ok = rsp_ok_q;
  assign link.rsp_data = rsp_data_q;
  assign link.awake = (st_q != FRA_ST_SLEEP);
  assign asleep_out = (st_q == FRA_ST_SLEEP);

  // ----------------------------------------
  // secure burn request
  // ----------------------------------------
  // address 0 carries the secret half, any other address status plus lock fuse
  always_comb begin
    burn_mask = '0;
    if (link.cmd_addr == 4'h0) begin
      burn_mask[`FRA_SECRET_HI:0] = link.cmd_arg;
    end else begin
      burn_mask[`FRA_LOCK_BIT:`FRA_STATUS_LO] = link.cmd_arg[23:0];
    end
  end

  assign burn_go = take && (link.cmd_op == FRA_OP_BURN) && !lock_burned;

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // only the two ROM words and readable fuse words answer
  always_comb begin
    rd_ok = 1'b1;
    rd_data = '0;
    unique case (link.cmd_addr)
      `FRA_ROM_ID_ADDR: rd_data = {WAFER_SN, ROM_MAKER[7:0], ROM_MAKER[15:8]};
      `FRA_ROM_REV_ADDR: rd_data = REVISION;
      `FRA_FUSE_W2_ADDR: rd_data = fuse[95:64];
      `FRA_FUSE_W3_ADDR: rd_data = fuse[127:96];
      // secret words refused, read as zero
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // digest stand-in
  // ----------------------------------------
  // keyed mix in place of the hash engine; it never leaves the device
  // secrets count only once locked
  assign secret_part = (lock_burned && link.cmd_sel[0]) ?
    ~fuse[`FRA_SECRET_HI:0] : 64'h0000_0000_0000_0000;
  assign serial_part = link.cmd_sel[1] ?
    {32'h0000_0000, fuse[127:96]} : 64'h0000_0000_0000_0000;
  // status fuses only via host extra input
  assign msg = chal_q ^ extra_q ^ secret_part ^ serial_part ^
    {40'h00_0000_0000, ROM_MAKER, fuse[95:88]};
  assign digest = {msg[50:0], msg[63:51]} ^ (msg >> 7) ^ MASK_KEY;

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // counts any awake cycle
  assign wdog_hit = (wdog_q >= WDOG_CYC - 1);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wdog_q <= '0;
    end else if (ce_in) begin
      if (st_q == FRA_ST_SLEEP) begin
        wdog_q <= '0;
      end else if (!wdog_hit) begin
        wdog_q <= wdog_q + 32'd1;
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // the watchdog wins over a pending command; no activity keeps it awake
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_q <= FRA_ST_SLEEP;
    end else if (ce_in) begin
      unique case (st_q)
        FRA_ST_SLEEP: if (link.wake) st_q <= FRA_ST_IDLE;
        FRA_ST_IDLE: begin
          if (wdog_hit) begin
            st_q <= FRA_ST_SLEEP;
          end else if (take) begin
            st_q <= FRA_ST_RESP;
          end
        end
        FRA_ST_RESP: st_q <= wdog_hit ? FRA_ST_SLEEP : FRA_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // verify steps
  // ----------------------------------------
  // steps must come in order
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      step_q <= 2'd0;
      chal_q <= '0;
      extra_q <= '0;
    end else if (ce_in) begin
      if (st_q == FRA_ST_SLEEP) begin
        step_q <= 2'd0;
      end else if (take) begin
        if (link.cmd_op == FRA_OP_V0) begin
          chal_q <= link.cmd_arg;
          extra_q <= '0;
          step_q <= 2'd1;
        end else if (link.cmd_op == FRA_OP_V1 && step_q == 2'd1) begin
          extra_q <= link.cmd_arg;
          step_q <= 2'd2;
        end else if (link.cmd_op == FRA_OP_V2 || link.cmd_op == FRA_OP_V1) begin
          step_q <= 2'd0;
        end
      end
    end
  end

  // ----------------------------------------
  // answer register
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rsp_ok_q <= 1'b0;
      rsp_data_q <= '0;
    end else if (ce_in && take) begin
      rsp_data_q <= '0;
      rsp_ok_q <= 1'b1;
      unique case (link.cmd_op)
        FRA_OP_READ: begin
          rsp_ok_q <= rd_ok;
          rsp_data_q <= rd_data;
        end
        FRA_OP_BURN: rsp_ok_q <= !lock_burned;
        FRA_OP_V0: rsp_ok_q <= 1'b1;
        FRA_OP_V1: rsp_ok_q <= (step_q == 2'd1);
        FRA_OP_V2: rsp_ok_q <= (step_q == 2'd2) && (digest == link.cmd_arg);
        default: rsp_ok_q <= 1'b0;
      endcase
    end
  end
endmodule // fra_device
`default_nettype wire

// >>> rtl/fra_host.sv
/*
  Host controller end: APB slave registers steer one link command at a time.
  Assumes an APB master at core clock and the device on the link interface.
*/
`default_nettype none
`include "fra_map.svh"
module fra_host
  import fra_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  fra_link_if.host link
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  fra_host_st_t st_q;
  logic [31:0] ctrl_q;
  logic [63:0] arg_q;
  logic done_q;
  logic ok_q;
  logic [31:0] rdata_q;
  logic wake_q;
  logic wr;
  logic go;
  logic mapped;

  assign wr = psel_in && penable_in && pwrite_in && ce_in;
  assign go = wr && (paddr_in == `FRA_REG_CTRL) && pwdata_in[`FRA_CTRL_GO_BIT];
  assign mapped = (paddr_in == `FRA_REG_CTRL) || (paddr_in == `FRA_REG_ARG_LO) ||
    (paddr_in == `FRA_REG_ARG_HI) || (paddr_in == `FRA_REG_STATUS) ||
    (paddr_in == `FRA_REG_RDATA);
  // zero-wait slave; frozen clock-enable stretches the access
  assign pready_out = ce_in;
  assign pslverr_out = psel_in && penable_in && !mapped;

  // software register writes; go and wake read back as zero
  // challenge written by software
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_q <= '0;
      arg_q <= '0;
    end else if (wr && st_q == FRA_HS_IDLE) begin
      if (paddr_in == `FRA_REG_CTRL) ctrl_q <= pwdata_in & 32'h0000_0f67;
      if (paddr_in == `FRA_REG_ARG_LO) arg_q[31:0] <= pwdata_in;
      if (paddr_in == `FRA_REG_ARG_HI) arg_q[63:32] <= pwdata_in;
    end
  end

  // read mux
  always_comb begin
    prdata_out = '0;
    unique case (paddr_in)
      `FRA_REG_CTRL: prdata_out = ctrl_q;
      `FRA_REG_ARG_LO: prdata_out = arg_q[31:0];
      `FRA_REG_ARG_HI: prdata_out = arg_q[63:32];
      `FRA_REG_STATUS: prdata_out = {28'h000_0000, link.awake, ok_q, done_q,
        st_q != FRA_HS_IDLE};
      `FRA_REG_RDATA: prdata_out = rdata_q;
      default: prdata_out = '0;
    endcase
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  // software must finish before the device watchdog expires
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wake_q <= 1'b0;
    end else if (ce_in) begin
      wake_q <= wr && (paddr_in == `FRA_REG_CTRL) && pwdata_in[`FRA_CTRL_WAKE_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_q <= FRA_HS_IDLE;
    end else if (ce_in) begin
      unique case (st_q)
        FRA_HS_IDLE: if (go && st_q == FRA_HS_IDLE) st_q <= FRA_HS_ISSUE;
        // a device that sleeps before taking the command ends the wait as a failed answer
        FRA_HS_ISSUE: if (link.cmd_ready || !link.awake) st_q <= FRA_HS_WAIT;
        FRA_HS_WAIT: if (link.rsp_valid || !link.awake) st_q <= FRA_HS_IDLE;
      endcase
    end
  end

  // answer capture; a new go clears done, a same-cycle answer wins
  // revision word passed through unjudged
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
      rdata_q <= '0;
    end else if (ce_in) begin
      if (st_q == FRA_HS_WAIT && (link.rsp_valid || !link.awake)) begin
        done_q <= 1'b1;
        ok_q <= link.rsp_valid && link.rsp_ok;
        rdata_q <= link.rsp_valid ? link.rsp_data : 32'h0000_0000;
      end else if (go) begin
        done_q <= 1'b0;
      end
    end
  end

  assign link.wake = wake_q;
  assign link.cmd_valid = (st_q == FRA_HS_ISSUE);
  assign link.cmd_op = fra_op_t'(ctrl_q[`FRA_CTRL_OP_LSB +: 3]);
  assign link.cmd_sel = ctrl_q[`FRA_CTRL_SEL_LSB +: 2];
  assign link.cmd_addr = ctrl_q[`FRA_CTRL_ADDR_LSB +: 4];
  // status values returned via the extra input
  assign link.cmd_arg = arg_q;
endmodule // fra_host
`default_nettype wire

// >>> tb/fra_link_checker.sv
/*
  Link checker: answer timing and read answers on the link.
  Assumes one clock domain and link signals as plain inputs.
*/
`default_nettype none
module fra_link_checker
  import fra_pkg::*;
#(
  parameter int unsigned WDOG_CYC = 64,
  parameter logic [15:0] ROM_MAKER = 16'h0000,
  parameter logic [15:0] WAFER_SN = 16'h0000,
  parameter logic [31:0] REVISION = 32'h0000_0000
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fra_op_t cmd_op,
  input wire logic [3:0] cmd_addr,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [31:0] rsp_data,
  input wire logic awake
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ----
  // helpers
  // ----
  logic take;
  logic [31:0] awake_cnt_q;
  assign take = cmd_valid && cmd_ready && ce_in;
  // length of the current awake run, bounds the watchdog
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !awake) awake_cnt_q <= 32'h0000_0000;
    else if (ce_in) awake_cnt_q <= awake_cnt_q + 32'h0000_0001;
  end
  sequence s_rd; take && cmd_op == FRA_OP_READ; endsequence
  sequence s_refused; rsp_valid && !rsp_ok && rsp_data == 32'h0000_0000; endsequence
  // ----
  // properties
  // ----
  property p_answer_next; take |=> rsp_valid || !awake; endproperty
  a_answer_next: assert property (p_answer_next) else $error("no answer after take");
  property p_answer_cause; rsp_valid |-> $past(take); endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("answer without take");
  property p_secret_hidden; s_rd ##0 (cmd_addr == 4'h2 || cmd_addr == 4'h3) |=> s_refused; endproperty
  a_secret_hidden: assert property (p_secret_hidden) else $error("secret word answered");
  property p_rom_bound; s_rd ##0 (cmd_addr > 4'h5) |=> s_refused; endproperty
  a_rom_bound: assert property (p_rom_bound) else $error("read past readable words");
  property p_word0;
    s_rd ##0 (cmd_addr == 4'h0) |=> rsp_valid && rsp_ok && rsp_data == {WAFER_SN, ROM_MAKER[7:0], ROM_MAKER[15:8]};
  endproperty
  a_word0: assert property (p_word0) else $error("identity word wrong");
  property p_word1; s_rd ##0 (cmd_addr == 4'h1) |=> rsp_valid && rsp_ok && rsp_data == REVISION; endproperty
  a_word1: assert property (p_word1) else $error("revision word wrong");
  property p_ready_awake; cmd_ready |-> awake; endproperty
  a_ready_awake: assert property (p_ready_awake) else $error("ready while asleep");
  // one cycle of slack allowed for the expiry edge itself
  property p_wdog; awake_cnt_q <= WDOG_CYC + 1; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not force sleep");
  property p_data_hold; !rsp_valid |-> $stable(rsp_data); endproperty
  a_data_hold: assert property (p_data_hold) else $error("answer data moved");
endmodule // fra_link_checker
`default_nettype wire

// >>> tb/tb_fuse_rom_identity_access.sv
/*
  Bench joining host and device ends over the link, driven by APB.
  Assumes package, map header, interface and both ends compiled first.
*/
`default_nettype none
`include "fra_map.svh"
module tb_fuse_rom_identity_access
  import fra_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WDOG = 1000;
  localparam logic [15:0] ROM_MAKER = 16'h4c7e; // arbitrary value
  localparam logic [15:0] WAFER = 16'h00a5;
  localparam logic [31:0] REV = 32'h0000_0003; // arbitrary value
  localparam logic [7:0] FMAKER = 8'h3c; // arbitrary value
  localparam logic [31:0] FSER = 32'h1234_5678;
  localparam logic [63:0] KEY = 64'h0f1e_2d3c_4b5a_6978;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, asleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mon_data, rs;
  logic [127:0] fuse_m;
  int errors, total_checks;
  fra_link_if link_bus();
  fra_host u_fra_host(.core_clk_in(clk), .reset_in(rst), .ce_in(ce), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link(link_bus.host));
  fra_device #(.WDOG_CYC(WDOG), .ROM_MAKER(ROM_MAKER), .WAFER_SN(WAFER), .REVISION(REV), .MAKER_FUSE(FMAKER),
    .SERIAL_FUSE(FSER), .MASK_KEY(KEY)) u_fra_device(.core_clk_in(clk), .reset_in(rst), .ce_in(ce),
    .link(link_bus.dev), .asleep_out(asleep));
  fra_link_checker #(.WDOG_CYC(WDOG), .ROM_MAKER(ROM_MAKER), .WAFER_SN(WAFER), .REVISION(REV)) u_chk(
    .core_clk_in(clk), .reset_in(rst), .ce_in(ce), .cmd_valid(link_bus.cmd_valid), .cmd_ready(link_bus.cmd_ready),
    .cmd_op(link_bus.cmd_op), .cmd_addr(link_bus.cmd_addr), .rsp_valid(link_bus.rsp_valid),
    .rsp_ok(link_bus.rsp_ok), .rsp_data(link_bus.rsp_data), .awake(link_bus.awake));
  // ----
  // clock, wire monitor, hang guard
  // ----
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (link_bus.rsp_valid === 1'b1) mon_data <= link_bus.rsp_data;
  initial begin
    #200_000;
    errors++;
    $display("timeout at %0t", $time);
    close_out();
  end
  // ----
  // checks and helpers
  // ----
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ok(input logic got, input logic exp);
    chk_data({31'h0, got}, {31'h0, exp});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // lfsr, seed 86001
  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction
  // expected digest: maker id always in, secrets only once locked
  function automatic logic [63:0] dig(input logic [63:0] ch, input logic [63:0] ex, input logic [1:0] sel);
    logic [63:0] m;
    m = ch ^ ex ^ {40'h0, ROM_MAKER, FMAKER};
    if (sel[0] && fuse_m[87] === 1'b0) m = m ^ ~fuse_m[63:0];
    if (sel[1]) m = m ^ {32'h0, fuse_m[127:96]};
    return {m[50:0], m[63:51]} ^ (m >> 7) ^ KEY;
  endfunction
  // one apb transfer; answer taken at the edge where pready is high, only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wake_up();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    apb(1'b1, `FRA_REG_CTRL, 32'h0000_0010, q, e);
    do begin
      @(negedge clk);
      n++;
    end while (link_bus.awake !== 1'b1 && n < 10);
    chk_ok(link_bus.awake, 1'b1);
    @(posedge clk);
  endtask
  // wait out the watchdog so a fresh awake window starts
  task automatic fresh();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (link_bus.awake !== 1'b0 && n < WDOG + 50);
    chk_ok(asleep, 1'b1);
    @(posedge clk);
    wake_up();
  endtask
  task automatic run_cmd(input fra_op_t op, input logic [1:0] sel, input logic [3:0] a, input logic [63:0] arg,
                         output logic ok, output logic [31:0] d);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    apb(1'b0, `FRA_REG_STATUS, 32'h0000_0000, q, e);
    if (q[3] !== 1'b1) wake_up();
    apb(1'b1, `FRA_REG_ARG_LO, arg[31:0], q, e);
    apb(1'b1, `FRA_REG_ARG_HI, arg[63:32], q, e);
    apb(1'b1, `FRA_REG_CTRL, {20'h0_0000, a, 1'b0, sel, 1'b0, 1'b1, op}, q, e);
    do begin
      apb(1'b0, `FRA_REG_STATUS, 32'h0000_0000, q, e);
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    chk_ok(q[1], 1'b1);
    ok = q[2];
    apb(1'b0, `FRA_REG_RDATA, 32'h0000_0000, d, e);
  endtask
  task automatic chk_read(input logic [3:0] a);
    logic ok;
    logic [31:0] d, e;
    case (a)
      4'h0: e = {WAFER, ROM_MAKER[7:0], ROM_MAKER[15:8]};
      4'h1: e = REV;
      4'h4: e = fuse_m[95:64];
      4'h5: e = fuse_m[127:96];
      default: e = 32'h0000_0000;
    endcase
    run_cmd(FRA_OP_READ, 2'b00, a, 64'h0, ok, d);
    chk_ok(ok, a inside {4'h0, 4'h1, 4'h4, 4'h5});
    chk_data(d, e);
    chk_data(mon_data, e);
  endtask
  task automatic burn(input logic [3:0] a, input logic [63:0] arg);
    logic ok, exp_ok;
    logic [31:0] d;
    exp_ok = fuse_m[87];
    run_cmd(FRA_OP_BURN, 2'b00, a, arg, ok, d);
    chk_ok(ok, exp_ok);
    if (exp_ok && a == 4'h0) fuse_m[63:0] &= ~arg;
    else if (exp_ok) fuse_m[87:64] &= ~arg[23:0];
  endtask
  task automatic vfy(input logic [1:0] sel, input logic good);
    logic ok;
    logic [31:0] d;
    logic [63:0] ch, ex;
    fresh();
    ch = {rnd(), rnd()};
    ex = {rnd(), rnd()};
    run_cmd(FRA_OP_V0, sel, 4'h0, ch, ok, d);
    run_cmd(FRA_OP_V1, sel, 4'h0, ex, ok, d);
    run_cmd(FRA_OP_V2, sel, 4'h0, dig(ch, ex, sel) ^ {63'h0, !good}, ok, d);
    chk_ok(ok, good);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic ok, e;
    logic [31:0] d;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errors = 0;
    total_checks = 0;
    rs = 32'h0001_4ff1;
    fuse_m = {FSER, FMAKER, {88{1'b1}}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h014, 32'h0000_0000, d, e);
    chk_ok(e, 1'b1);
    chk_data(d, 32'h0000_0000);
    for (int a = 0; a < 16; a++) chk_read(a[3:0]);
    $display("test reads done");
    burn(4'h0, {rnd(), rnd()});
    burn(4'h0, {rnd(), rnd()});
    d = rnd();
    burn(4'h1, {41'h0, d[22:0]});
    chk_read(4'h4);
    chk_read(4'h5);
    // a reset must not bring burned fuses back
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk_read(4'h4);
    $display("test burns done");
    for (int s = 0; s < 4; s++) begin
      vfy(s[1:0], 1'b1);
      vfy(s[1:0], 1'b0);
    end
    fresh();
    run_cmd(FRA_OP_V2, 2'b00, 4'h0, 64'h0, ok, d);
    chk_ok(ok, 1'b0);
    run_cmd(FRA_OP_V1, 2'b00, 4'h0, 64'h0, ok, d);
    chk_ok(ok, 1'b0);
    $display("test unlocked verify done");
    burn(4'h1, 64'h0000_0000_0080_0000);
    chk_read(4'h4);
    for (int s = 0; s < 4; s++) begin
      vfy(s[1:0], 1'b1);
    end
    burn(4'h0, 64'hffff_ffff_ffff_ffff);
    chk_read(4'h4);
    vfy(2'b01, 1'b1);
    // frozen enable: the bus stalls and the awake device keeps its state
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk_ok(pready, 1'b0);
    chk_ok(asleep, 1'b0);
    ce <= 1'b1;
    $display("test locked done");
    close_out();
  end
endmodule // tb_fuse_rom_identity_access
`default_nettype wire
